// ==== include/ufas_regs.svh ====
// Register offsets, field positions and reset values of the address and status block.
`ifndef UFAS_REGS_SVH
`define UFAS_REGS_SVH
`define UFAS_OFF_ADDR 12'h000
`define UFAS_OFF_STAT 12'h004
`define UFAS_OFF_MASK 12'h008
`define UFAS_ADDR_RST 7'h00
`define UFAS_FLAGS_RST 8'h00
`define UFAS_FLAG_MASK 8'hfd
`define UFAS_BIT_SETUP_OVERWRITE_FLAG 0
`define UFAS_BIT_SETUP 2
`define UFAS_BIT_PORT_POWER_ON_FLAG 3
`define UFAS_BIT_PORT_POWER_OFF_FLAG 4
`define UFAS_BIT_RESUME 5
`define UFAS_BIT_SUSP 6
`define UFAS_BIT_HRST 7
`define UFAS_NFLAGS 8
`endif

// ==== include/ufas_pkg.sv ====
// Types shared by the address and status block.
package ufas_pkg;
   typedef logic [7:0] ufas_byte_t;
   typedef logic [6:0] ufas_addr_t;
endpackage : ufas_pkg

// ==== hdl/ufas_flag.sv ====
// One sticky event flag: set by hardware, cleared by writing one.
`timescale 1ns/1ns
`default_nettype none
module ufas_flag (
   // Clock and resets.
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic func_rst,
   input wire logic keep_on_func_rst,
   // Event and clear.
   input wire logic set_evt,
   input wire logic clr,
   // State.
   output logic flag_q
);
   logic flag_d;

   always_comb begin
      flag_d = flag_q;
      if (clr) begin
         flag_d = 1'b0;
      end
      if (func_rst && !keep_on_func_rst) begin
         flag_d = 1'b0;
      end
      // A set in the same cycle as a clear wins, so no event is lost.
      if (set_evt) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule : ufas_flag
`default_nettype wire

// ==== hdl/ufas_top.sv ====
// APB register bank holding the function address and sticky event flags.
//
// Behaviour
// - Seven-bit address, resets zero, bit seven zero.
// - Flags set by hardware, write one clears.
// - Flag and mask both set raise interrupt.
// - Setup over pending setup sets bit 0.
// - Setup sets bit 2; endpoint 0 NAKed.
// - Port power-on request sets bit 3.
// - Port power-off request sets bit 4.
// - Global or selective suspend sets bit 6.
// - Host port reset sets bit 7.
// - Host reset flag survives function reset.
`timescale 1ns/1ns
`default_nettype none
`include "ufas_regs.svh"
module ufas_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // USB engine events, one-cycle pulses on ref_clk.
   input wire logic func_rst,
   input wire logic setup_rx,
   input wire logic setup_buf_full,
   input wire logic port_power_on_req,
   input wire logic port_power_off_req,
   input wire logic resume_det,
   input wire logic suspend_det,
   input wire logic host_reset_det,
   // To the USB engine and processor.
   output logic [6:0] device_address_field,
   output logic ep0_force_nak,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   ufas_pkg::ufas_addr_t addr_q;
   ufas_pkg::ufas_addr_t addr_d;
   ufas_pkg::ufas_byte_t mask_q;
   ufas_pkg::ufas_byte_t mask_d;
   ufas_pkg::ufas_byte_t flags;
   ufas_pkg::ufas_byte_t evt;
   ufas_pkg::ufas_byte_t clr;
   ufas_pkg::ufas_byte_t keep;
   logic [31:0] prdata_d;
   logic wr_acc;
   logic rd_acc;
   logic hit;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `UFAS_OFF_ADDR) || (a == `UFAS_OFF_STAT) || (a == `UFAS_OFF_MASK);
   endfunction : is_mapped

   // Single-cycle access phase: every transfer completes with no wait state.
   assign pready = 1'b1;
   assign hit = is_mapped(paddr);
   assign pslverr = psel && penable && !hit;
   assign wr_acc = psel && penable && pwrite && hit && pstrb[0];
   assign rd_acc = psel && !penable && !pwrite;

   ////////////////////////////////////////////////////////////////////////////////
   // Event vector in status bit order; bit 1 is reserved and never set.
   always_comb begin
      evt = 8'h00;
      evt[`UFAS_BIT_SETUP_OVERWRITE_FLAG] = setup_rx && setup_buf_full;
      evt[`UFAS_BIT_SETUP] = setup_rx;
      evt[`UFAS_BIT_PORT_POWER_ON_FLAG] = port_power_on_req;
      evt[`UFAS_BIT_PORT_POWER_OFF_FLAG] = port_power_off_req;
      evt[`UFAS_BIT_RESUME] = resume_det;
      evt[`UFAS_BIT_SUSP] = suspend_det;
      evt[`UFAS_BIT_HRST] = host_reset_det;
      keep = 8'h00;
      keep[`UFAS_BIT_HRST] = 1'b1;
      clr = 8'h00;
      if (wr_acc && paddr == `UFAS_OFF_STAT) begin
         clr = pwdata[7:0] & `UFAS_FLAG_MASK;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `UFAS_NFLAGS; gi++) begin : g_flag
         if (gi == 1) begin : g_rsv
            assign flags[gi] = 1'b0;
         end else begin : g_live
            ufas_flag u_flag (
               .ref_clk(ref_clk),
               .nrst(nrst),
               .func_rst(func_rst),
               .keep_on_func_rst(keep[gi]),
               .set_evt(evt[gi]),
               .clr(clr[gi]),
               .flag_q(flags[gi])
            );
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Address and mask registers; the function reset clears them as well.
   always_comb begin
      addr_d = addr_q;
      mask_d = mask_q;
      if (func_rst) begin
         addr_d = `UFAS_ADDR_RST;
         mask_d = `UFAS_FLAGS_RST;
      end
      if (wr_acc && paddr == `UFAS_OFF_ADDR) begin
         addr_d = pwdata[6:0];
      end
      if (wr_acc && paddr == `UFAS_OFF_MASK) begin
         mask_d = pwdata[7:0] & `UFAS_FLAG_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= `UFAS_ADDR_RST;
         mask_q <= `UFAS_FLAGS_RST;
      end else begin
         addr_q <= addr_d;
         mask_q <= mask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data is captured in the setup cycle so it is a flop in the access phase.
   always_comb begin
      prdata_d = prdata;
      if (rd_acc) begin
         prdata_d = 32'h0000_0000;
         case (paddr)
            `UFAS_OFF_ADDR: prdata_d = {25'h000_0000, addr_q};
            `UFAS_OFF_STAT: prdata_d = {24'h00_0000, flags};
            `UFAS_OFF_MASK: prdata_d = {24'h00_0000, mask_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= prdata_d;
      end
   end

   assign device_address_field = addr_q;
   assign ep0_force_nak = flags[`UFAS_BIT_SETUP];
   assign irq = |(flags & mask_q);
endmodule : ufas_top
`default_nettype wire

// ==== sim/ufas_props.sv ====
// Checker of the address and status block, seen from its top ports.
`timescale 1ns/1ns
`default_nettype none
module ufas_props (
   input wire logic ref_clk, nrst, psel, penable, pwrite, func_rst, setup_rx, ep0_force_nak,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   input wire logic [6:0] device_address_field
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic wr;
   logic clr_setup;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign clr_setup = wr && paddr == 12'h004 && pwdata[2];
   addr_read_a: assert property (psel && !penable && !pwrite && paddr == 12'h000
      |=> prdata[31:7] == 25'h0000000) else $error("address read shows upper bits");
   stat_read_a: assert property (psel && !penable && !pwrite && paddr == 12'h004
      |=> prdata[31:8] == 24'h000000 && !prdata[1]) else $error("status reserved bits set");
   addr_load_a: assert property (wr && paddr == 12'h000 && !func_rst
      |=> device_address_field == $past(pwdata[6:0])) else $error("address not loaded");
   frst_addr_a: assert property (func_rst && !(wr && paddr == 12'h000)
      |=> device_address_field == 7'h00)
      else $error("address kept over function reset");
   setup_nak_a: assert property (setup_rx |=> ep0_force_nak) else $error("no nak after setup");
   nak_hold_a: assert property (ep0_force_nak && !clr_setup && !func_rst |=> ep0_force_nak)
      else $error("setup flag dropped");
   nak_clear_a: assert property (clr_setup && !setup_rx |=> !ep0_force_nak)
      else $error("setup flag not cleared");
   nak_hw_a: assert property (!ep0_force_nak && !setup_rx |=> !ep0_force_nak)
      else $error("setup flag set without event");
endmodule : ufas_props
`default_nettype wire

// ==== sim/ufas_usb_eng.sv ====
// USB engine model: turns one-cycle request bits into event pulses.
`timescale 1ns/1ns
`default_nettype none
module ufas_usb_eng (
   input wire logic ref_clk,
   input wire logic [7:0] kick,
   output logic setup_rx, setup_buf_full, pwr_on, pwr_off, resume, suspend, host_rst
);
   always_ff @(posedge ref_clk) begin
      setup_rx <= kick[2] | kick[0];
      setup_buf_full <= kick[0];
      pwr_on <= kick[3];
      pwr_off <= kick[4];
      resume <= kick[5];
      suspend <= kick[6];
      host_rst <= kick[7];
   end
endmodule : ufas_usb_eng
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench of the address and status block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, func_rst = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, prdata;
   logic [7:0] kick = 0;
   logic pready, pslverr, srx, sbf, pon, poff, res, sus, hrst, nak, irq;
   logic [6:0] dev_addr;
   int n_fail = 0, tests_run = 0, cyc = 0;
   logic [7:0] rows[7] = '{8'h04, 8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
   logic [7:0] exps[7] = '{8'h04, 8'h05, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
   ufas_top i_ufas_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .func_rst(func_rst), .setup_rx(srx),
      .setup_buf_full(sbf), .port_power_on_req(pon), .port_power_off_req(poff),
      .resume_det(res), .suspend_det(sus), .host_reset_det(hrst),
      .device_address_field(dev_addr), .ep0_force_nak(nak), .irq(irq));
   ufas_usb_eng i_ufas_usb_eng (.ref_clk(ref_clk), .kick(kick), .setup_rx(srx),
      .setup_buf_full(sbf), .pwr_on(pon), .pwr_off(poff), .resume(res), .suspend(sus),
      .host_rst(hrst));
   always #50 ref_clk = ~ref_clk;
   task stop_test;
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         stop_test();
      end
   end
   // Setup then access, held until pready is seen high at a rising edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk) penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata; err = pslverr; psel <= 0; penable <= 0;
      @(posedge ref_clk);
   endtask : apb
   task ev(input logic [7:0] k);
      kick <= k;
      @(posedge ref_clk) kick <= 0;
      repeat (2) @(posedge ref_clk);
   endtask : ev
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      apb(0, 12'h000, 0); `CHK(rd, 32'h0)
      apb(1, 12'h000, 32'hff); apb(0, 12'h000, 0); `CHK(rd, 32'h7f)
      `CHK(dev_addr, 7'h7f)
      apb(1, 12'h008, 32'hff);
      for (int i = 0; i < 7; i++) begin
         ev(rows[i]); apb(0, 12'h004, 0); `CHK(rd[7:0], exps[i])
         `CHK(irq, 1'b1)
         apb(1, 12'h004, {24'h0, exps[i]}); apb(0, 12'h004, 0); `CHK(rd, 32'h0)
      end
      ev(8'hc4); apb(1, 12'h004, 0); apb(0, 12'h004, 0); `CHK(rd, 32'hc4)
      `CHK(nak, 1'b1)
      func_rst <= 1;
      @(posedge ref_clk) func_rst <= 0;
      apb(0, 12'h004, 0); `CHK(rd, 32'h80)
      `CHK(irq, 1'b0)
      apb(1, 12'h008, 32'h80); `CHK(irq, 1'b1)
      apb(0, 12'h0fc, 0); `CHK({err, rd}, 33'h100000000)
      `CHK(pready, 1'b1)
      stop_test();
   end
endmodule : testbench
bind ufas_top ufas_props i_ufas_props (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .func_rst(func_rst), .setup_rx(setup_rx),
   .ep0_force_nak(ep0_force_nak), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pstrb(pstrb), .device_address_field(device_address_field));
`default_nettype wire
